// File: ccw_calendar.sv
// Combinational carry ripple from seconds up through the year
`timescale 1ns/1ps
`include "ccw_regs.svh"

module ccw_calendar (
    input wire ccw_pkg::ccw_date_s cur_i,
    output ccw_pkg::ccw_date_s nxt_o
);

    // Month length, full Gregorian leap rule
    function automatic logic [4:0] ccw_month_len(input logic [15:0] y, input logic [3:0] m);
        logic leap;
        leap = ((y % 16'd4) == 16'd0) && (((y % 16'd100) != 16'd0) || ((y % 16'd400) == 16'd0));
        case (m)
            4'h2: ccw_month_len = leap ? 5'd29 : 5'd28;
            4'h4, 4'h6, 4'h9, 4'hb: ccw_month_len = 5'd30;
            default: ccw_month_len = 5'd31;
        endcase
    endfunction

    // One second has elapsed: ripple carries
    always_comb begin
        nxt_o = cur_i;
        nxt_o.subsec = `CCW_SUBSEC_TOP;
        if (cur_i.sec != 6'd59) begin
            nxt_o.sec = cur_i.sec + 6'd1;
        end else begin
            nxt_o.sec = 6'd0;
            if (cur_i.min != 6'd59) begin
                nxt_o.min = cur_i.min + 6'd1;
            end else begin
                nxt_o.min = 6'd0;
                if (cur_i.hour != 5'd23) begin
                    nxt_o.hour = cur_i.hour + 5'd1;
                end else begin
                    nxt_o.hour = 5'd0;
                    // Sunday wraps back to Monday
                    nxt_o.wday = (cur_i.wday >= `CCW_WDAY_LAST) ? 3'h1 : cur_i.wday + 3'h1;
                    if (cur_i.day < ccw_month_len(cur_i.year, cur_i.month)) begin
                        nxt_o.day = cur_i.day + 5'd1;
                    end else begin
                        nxt_o.day = 5'd1;
                        if (cur_i.month < 4'hc) begin
                            nxt_o.month = cur_i.month + 4'h1;
                        end else begin
                            nxt_o.month = 4'h1;
                            nxt_o.year = cur_i.year + 16'd1;
                        end
                    end
                end
            end
        end
    end

endmodule

// File: ccw_pkg.sv
// Types shared by the calendar clock modules
package ccw_pkg;

    typedef enum logic [1:0] {
        CCW_CAL_NONE,
        CCW_CAL_ADD,
        CCW_CAL_DROP
    } ccw_cal_mode_e;

    typedef struct packed {
        logic [15:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [2:0] wday;
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
        logic [7:0] subsec;
    } ccw_date_s;

    typedef struct packed {
        ccw_date_s date;
        logic [6:0] presc;
        logic [19:0] win;
        logic signed [10:0] cal;
        logic [16:0] ms_acc;
        logic wk_en;
        logic [15:0] wk_period;
        logic [15:0] wk_cnt;
        logic wk_event;
        logic wk_wake;
        logic wk_handler;
        logic st_cap;
        logic st_done;
        logic [15:0] st_ms;
        logic st_por;
        logic st_ext;
    } ccw_state_s;

endpackage

// File: ccw_regs.svh
// Constants for the calendar clock: timing counts, field limits and reset values
`ifndef CCW_REGS_SVH
`define CCW_REGS_SVH

`define CCW_TICK_HZ 32768
`define CCW_PRESC_W 7
`define CCW_SUBSEC_TOP 8'hff
`define CCW_SUBSEC_END 8'h00
`define CCW_CAL_WIN_S 32
`define CCW_CAL_WIN_TICKS (`CCW_CAL_WIN_S * `CCW_TICK_HZ)
`define CCW_CAL_WIN_BITS 20
`define CCW_CAL_SLOT_BITS 11
`define CCW_CAL_W 11
`define CCW_CAL_MIN 11'sh601
`define CCW_CAL_MAX 11'sh200
`define CCW_MS_PER_S 16'h03e8
`define CCW_ACC_W 17
`define CCW_WK_W 16
`define CCW_INFO_MS_W 16
`define CCW_INFO_POR_BIT 16
`define CCW_INFO_EXT_BIT 17
`define CCW_INFO_W 18
`define CCW_RST_YEAR 16'h07d0
`define CCW_RST_MONTH 4'h1
`define CCW_RST_DAY 5'h01
`define CCW_RST_WDAY 3'h6
`define CCW_WDAY_LAST 3'h7

`endif

// File: ccw_top.sv
// Calendar clock with periodic wakeup, startup report and smooth calibration
// Behaviour
// - The clock holds year, month, day, weekday, hours, minutes, seconds and subseconds as one record.
// - Weekday runs 1 to 7, Monday being 1 and Sunday 7.
// - Subseconds count down from 255 to 0 inside each second.
// - Writing a full record loads every field; reading shows the present values.
// - An enabled wakeup timer fires once every timeout in milliseconds and keeps running.
// - Every wakeup firing can bring the system out of both stop and standby.
// - Configuring the wakeup timer without a timeout disables it and stops all firings.
// - Every wakeup firing raises an event, and a registered handler is triggered each time.
// - The startup report's low sixteen bits give the startup time in milliseconds.
// - The startup report sets bit 16 after a power-on reset.
// - The startup report sets bit 17 after an external reset.
// - Calibration is a signed value from -511 to 512 that software writes and reads.
// - Calibration adds or removes that many ticks of the 32768 Hz source in each 2^20 tick window.
// - Each added tick speeds the clock by one part in 2^20, each removed tick slows it by the same.
`timescale 1ns/1ps
`include "ccw_regs.svh"

module ccw_top (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic tick_i,
    input wire logic set_i,
    input wire logic [15:0] set_year_i,
    input wire logic [3:0] set_month_i,
    input wire logic [4:0] set_day_i,
    input wire logic [2:0] set_wday_i,
    input wire logic [4:0] set_hour_i,
    input wire logic [5:0] set_min_i,
    input wire logic [5:0] set_sec_i,
    input wire logic [7:0] set_subsec_i,
    input wire logic wk_cfg_i,
    input wire logic wk_timeout_given_i,
    input wire logic [15:0] wk_timeout_ms_i,
    input wire logic wk_handler_en_i,
    input wire logic cal_wr_i,
    input wire logic signed [10:0] cal_i,
    input wire logic por_flag_i,
    input wire logic ext_reset_flag_i,
    input wire logic osc_ready_i,
    output logic [15:0] year_o,
    output logic [3:0] month_o,
    output logic [4:0] day_o,
    output logic [2:0] wday_o,
    output logic [4:0] hour_o,
    output logic [5:0] min_o,
    output logic [5:0] sec_o,
    output logic [7:0] subsec_o,
    output logic wk_event_o,
    output logic wk_wake_o,
    output logic wk_handler_o,
    output logic wk_active_o,
    output logic [17:0] info_o,
    output logic signed [10:0] cal_o
);

    // Registered state and the combinational values that feed it
    ccw_pkg::ccw_state_s s_q;
    ccw_pkg::ccw_state_s s_d;
    ccw_pkg::ccw_date_s date_next;
    ccw_pkg::ccw_cal_mode_e cal_mode;
    logic [9:0] cal_mag;
    logic [7:0] presc_sum;
    logic [16:0] acc_sum;
    logic ms_pulse;
    logic [15:0] wk_next;

    // Second rollover arithmetic lives in its own module
    ccw_calendar u_calendar (
        .cur_i(s_q.date),
        .nxt_o(date_next)
    );

    // Calibration slot choice: one slot every 2048 ticks, up to 512 per window
    // Slots used are the first cal_mag of the window, so the correction bunches at its start
    always_comb begin
        cal_mag = s_q.cal[10] ? 10'(-s_q.cal) : s_q.cal[9:0];
        cal_mode = ccw_pkg::CCW_CAL_NONE;
        if (s_q.win[`CCW_CAL_SLOT_BITS-1:0] == 11'h000 &&
            {1'b0, s_q.win[`CCW_CAL_WIN_BITS-1:`CCW_CAL_SLOT_BITS]} < cal_mag) begin
            cal_mode = s_q.cal[10] ? ccw_pkg::CCW_CAL_DROP : ccw_pkg::CCW_CAL_ADD;
        end
    end

    // Prescaler step: two on an added tick, none on a removed one
    // Limitation: a record load on a slot tick loses that one correction
    always_comb begin
        case (cal_mode)
            ccw_pkg::CCW_CAL_ADD: presc_sum = {1'b0, s_q.presc} + 8'h02;
            ccw_pkg::CCW_CAL_DROP: presc_sum = {1'b0, s_q.presc};
            default: presc_sum = {1'b0, s_q.presc} + 8'h01;
        endcase
    end

    // Exact millisecond strobe: add 1000 per tick, wrap at 32768
    // Raw source on purpose, so calibration never bends wakeup intervals
    assign acc_sum = s_q.ms_acc + {1'b0, `CCW_MS_PER_S};
    assign ms_pulse = tick_i && (acc_sum >= 17'(`CCW_TICK_HZ));
    assign wk_next = s_q.wk_cnt + 16'h0001;

    // Next state of the whole block
    always_comb begin
        s_d = s_q;
        s_d.wk_event = 1'b0;
        s_d.wk_wake = 1'b0;
        s_d.wk_handler = 1'b0;

        // Timekeeping; a software load wins over a tick in the same cycle
        // Subseconds move only when the prescaler carries out of its top bit
        if (set_i) begin
            s_d.date.year = set_year_i;
            s_d.date.month = set_month_i;
            s_d.date.day = set_day_i;
            s_d.date.wday = set_wday_i;
            s_d.date.hour = set_hour_i;
            s_d.date.min = set_min_i;
            s_d.date.sec = set_sec_i;
            s_d.date.subsec = set_subsec_i;
            s_d.presc = 7'h00;
        end else if (tick_i) begin
            s_d.presc = presc_sum[6:0];
            if (presc_sum[7]) begin
                if (s_q.date.subsec == `CCW_SUBSEC_END) begin
                    s_d.date = date_next;
                end else begin
                    s_d.date.subsec = s_q.date.subsec - 8'h01;
                end
            end
        end

        // Window position always follows the raw source
        if (tick_i) begin
            s_d.win = s_q.win + 20'h00001;
            s_d.ms_acc = ms_pulse ? acc_sum - 17'(`CCW_TICK_HZ) : acc_sum;
        end

        // Calibration write, clamped to the legal span
        // Saturating beats wrapping, which would flip the sign of the correction
        if (cal_wr_i) begin
            if (cal_i < `CCW_CAL_MIN) begin
                s_d.cal = `CCW_CAL_MIN;
            end else if (cal_i > `CCW_CAL_MAX) begin
                s_d.cal = `CCW_CAL_MAX;
            end else begin
                s_d.cal = cal_i;
            end
        end

        // Wakeup timer; reconfiguring restarts the interval
        // Reload to zero keeps each period exact whatever the strobe phase
        if (wk_cfg_i) begin
            if (wk_timeout_given_i && wk_timeout_ms_i != 16'h0000) begin
                s_d.wk_en = 1'b1;
                s_d.wk_period = wk_timeout_ms_i;
            end else begin
                s_d.wk_en = 1'b0;
            end
            s_d.wk_cnt = 16'h0000;
        end else if (s_q.wk_en && ms_pulse) begin
            if (wk_next >= s_q.wk_period) begin
                s_d.wk_cnt = 16'h0000;
                s_d.wk_event = 1'b1;
                s_d.wk_wake = 1'b1;
                s_d.wk_handler = wk_handler_en_i;
            end else begin
                s_d.wk_cnt = wk_next;
            end
        end

        // Startup report: reset cause caught once after release
        // Count saturates, so a dead oscillator reads as the top value
        if (!s_q.st_cap) begin
            s_d.st_cap = 1'b1;
            s_d.st_por = por_flag_i;
            s_d.st_ext = ext_reset_flag_i;
        end
        if (!s_q.st_done) begin
            if (osc_ready_i) begin
                s_d.st_done = 1'b1;
            end else if (ms_pulse && s_q.st_ms != 16'hffff) begin
                s_d.st_ms = s_q.st_ms + 16'h0001;
            end
        end
    end

    // State register; reset lands on a fixed date
    // Only constants here; the cause flags are caught on the first clock instead
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
            s_q.date.year <= `CCW_RST_YEAR;
            s_q.date.month <= `CCW_RST_MONTH;
            s_q.date.day <= `CCW_RST_DAY;
            s_q.date.wday <= `CCW_RST_WDAY;
            s_q.date.subsec <= `CCW_SUBSEC_TOP;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs taken straight from the state register
    // Wake and event come from twin bits set together, so they always pulse as one
    assign year_o = s_q.date.year;
    assign month_o = s_q.date.month;
    assign day_o = s_q.date.day;
    assign wday_o = s_q.date.wday;
    assign hour_o = s_q.date.hour;
    assign min_o = s_q.date.min;
    assign sec_o = s_q.date.sec;
    assign subsec_o = s_q.date.subsec;
    assign wk_event_o = s_q.wk_event;
    assign wk_wake_o = s_q.wk_wake;
    assign wk_handler_o = s_q.wk_handler;
    assign wk_active_o = s_q.wk_en;
    assign info_o = {s_q.st_ext, s_q.st_por, s_q.st_ms};
    assign cal_o = s_q.cal;

endmodule

// File: ccw_top_sva.sv
// Port-level concurrent checks for the calendar clock
`timescale 1ns/1ps
module ccw_top_sva (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic tick_i,
    input wire logic set_i,
    input wire logic [2:0] set_wday_i,
    input wire logic [5:0] set_sec_i,
    input wire logic [7:0] set_subsec_i,
    input wire logic cal_wr_i,
    input wire logic signed [10:0] cal_i,
    input wire logic osc_ready_i,
    input wire logic [2:0] wday_o,
    input wire logic [5:0] sec_o,
    input wire logic [7:0] subsec_o,
    input wire logic wk_event_o,
    input wire logic wk_wake_o,
    input wire logic wk_handler_o,
    input wire logic wk_active_o,
    input wire logic [17:0] info_o,
    input wire logic signed [10:0] cal_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // Record fields follow the load strobe one cycle later
    set_load_a: assert property (set_i |=> {wday_o, sec_o, subsec_o} ==
        $past({set_wday_i, set_sec_i, set_subsec_i})) else $error("record load not seen");
    wday_range_a: assert property (wday_o inside {[3'h1:3'h7]}) else $error("weekday out of range");
    // Subseconds move only on a tick, and then only down by one or wrapping
    subsec_hold_a: assert property (!tick_i && !set_i |=> $stable(subsec_o)) else $error("subsec moved");
    subsec_step_a: assert property (!set_i && tick_i |=> subsec_o == $past(subsec_o) ||
        subsec_o == $past(subsec_o) - 8'h01 || ($past(subsec_o) == 8'h00 && subsec_o == 8'hff))
        else $error("subsec step wrong");
    sec_carry_a: assert property (!set_i ##1 sec_o != $past(sec_o) |->
        $past(subsec_o) == 8'h00 && subsec_o == 8'hff) else $error("seconds moved without wrap");
    wake_pair_a: assert property (wk_event_o == wk_wake_o) else $error("wake and event differ");
    handler_gate_a: assert property (wk_handler_o |-> wk_event_o) else $error("stray handler pulse");
    // Firings are single-cycle and a timeout is never below one millisecond
    event_pulse_a: assert property (wk_event_o |=> !wk_event_o [*8]) else $error("event too long");
    fire_active_a: assert property (wk_event_o |-> $past(wk_active_o)) else $error("fired while off");
    cal_range_a: assert property (cal_o >= -11'sd511 && cal_o <= 11'sd512) else $error("cal range");
    cal_write_a: assert property (cal_wr_i && cal_i >= -11'sd511 && cal_i <= 11'sd512 |=>
        cal_o == $past(cal_i)) else $error("cal write lost");
    info_freeze_a: assert property (osc_ready_i [*3] |-> $stable(info_o)) else $error("report moved");
endmodule

bind ccw_top ccw_top_sva chk_u (.*);

// File: tb_ccw_top.sv
// Self-checking bench for the calendar clock
`timescale 1ns/1ps
module tb_ccw_top;
    logic clock_i = 1'b0, rstn_i = 1'b0, tick_i = 1'b0, set_i = 1'b0, cfg_i = 1'b0, given = 1'b0;
    logic hen = 1'b0, cal_wr_i = 1'b0, por = 1'b1, ext = 1'b0, osc = 1'b0;
    logic [15:0] wk_ms = 16'h0000;
    logic signed [10:0] cal_i = 11'sh000;
    ccw_pkg::ccw_date_s r = '0;
    wire ccw_pkg::ccw_date_s q;
    logic ev, wk, hd, act;
    logic [17:0] info;
    logic signed [10:0] cal_o;
    int bad_count = 0, samples_checked = 0, ev_n = 0, hd_n = 0, wk_n = 0, cyc_n = 0;
    int cv[7] = '{600, -600, 512, -511, 513, -512, 0};
    always #20 clock_i = ~clock_i;
    ccw_top dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .tick_i(tick_i), .set_i(set_i),
        .set_year_i(r.year), .set_month_i(r.month), .set_day_i(r.day), .set_wday_i(r.wday),
        .set_hour_i(r.hour), .set_min_i(r.min), .set_sec_i(r.sec), .set_subsec_i(r.subsec),
        .wk_cfg_i(cfg_i), .wk_timeout_given_i(given), .wk_timeout_ms_i(wk_ms), .wk_handler_en_i(hen),
        .cal_wr_i(cal_wr_i), .cal_i(cal_i), .por_flag_i(por), .ext_reset_flag_i(ext), .osc_ready_i(osc),
        .year_o(q.year), .month_o(q.month), .day_o(q.day), .wday_o(q.wday), .hour_o(q.hour),
        .min_o(q.min), .sec_o(q.sec), .subsec_o(q.subsec), .wk_event_o(ev), .wk_wake_o(wk),
        .wk_handler_o(hd), .wk_active_o(act), .info_o(info), .cal_o(cal_o));
    // Pulse counters and a hang guard well above the few thousand cycles needed
    always @(posedge clock_i) begin
        cyc_n <= cyc_n + 1;
        if (ev === 1'b1) ev_n++;
        if (hd === 1'b1) hd_n++;
        if (wk === 1'b1) wk_n++;
        if (cyc_n == 20000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    // Ticks are spaced at random so the time base never sees a fixed rhythm
    task automatic ticks(input int n);
        repeat (n) begin
            tick_i = 1'b1;
            cyc(1);
            tick_i = 1'b0;
            cyc($urandom_range(2, 1));
        end
    endtask
    task automatic load();
        set_i = 1'b1;
        cyc(1);
        set_i = 1'b0;
    endtask
    task automatic cfg(input logic g, input logic [15:0] ms);
        given = g;
        wk_ms = ms;
        cfg_i = 1'b1;
        cyc(1);
        cfg_i = 1'b0;
        cyc(1);
    endtask
    // A fresh reset parks the window at position 0, a slot for any nonzero setting
    task automatic cal_run(input logic signed [10:0] c, input int n, input logic [7:0] e);
        rstn_i = 1'b0;
        cyc(2);
        rstn_i = 1'b1;
        cyc(1);
        cal_i = c;
        cal_wr_i = 1'b1;
        cyc(1);
        cal_wr_i = 1'b0;
        r.subsec = 8'h05;
        load();
        ticks(n);
        chk("cal slot", e, q.subsec);
    endtask
    function automatic logic signed [10:0] clamp(input int v);
        return (v < -511) ? -11'sd511 : (v > 512) ? 11'sd512 : v[10:0];
    endfunction
    initial begin
        void'($urandom(52));
        cyc(4);
        rstn_i = 1'b1;
        cyc(1);
        r = '{16'h07d0, 4'h1, 5'h01, 3'h6, 5'h00, 6'h00, 6'h00, 8'hff};
        chk("reset date", r, q);
        // 100 ticks hold three millisecond strobes before the oscillator is ready
        ticks(100);
        cyc(3);
        osc = 1'b1;
        cyc(3);
        chk("info", 18'h10003, info);
        $display("test startup done");
        repeat (4) begin
            r = '{16'($urandom), 4'($urandom_range(12, 1)), 5'($urandom_range(28, 1)),
                3'($urandom_range(7, 1)), 5'($urandom_range(23, 0)), 6'($urandom_range(59, 0)),
                6'($urandom_range(59, 0)), 8'($urandom)};
            load();
            chk("record", r, q);
            cyc(3);
            chk("record held", r, q);
        end
        r.subsec = 8'h05;
        load();
        ticks(127);
        chk("subsec", 8'h05, q.subsec);
        ticks(1);
        chk("subsec", 8'h04, q.subsec);
        r = '{16'h07cf, 4'hc, 5'h1f, 3'h7, 5'h17, 6'h3b, 6'h3b, 8'h00};
        load();
        ticks(128);
        r = '{16'h07d0, 4'h1, 5'h01, 3'h1, 5'h00, 6'h00, 6'h00, 8'hff};
        chk("rollover", r, q);
        $display("test calendar done");
        hen = 1'b1;
        cfg(1'b1, 16'h0002);
        chk("active", 1'b1, act);
        ev_n = 0;
        hd_n = 0;
        wk_n = 0;
        ticks(656);
        cyc(3);
        chk("firings", 10, ev_n);
        chk("wake", 10, wk_n);
        chk("handler", 10, hd_n);
        hen = 1'b0;
        hd_n = 0;
        ticks(131);
        cyc(3);
        chk("handler off", 0, hd_n);
        cfg(1'b0, 16'h0002);
        chk("active", 1'b0, act);
        ev_n = 0;
        ticks(200);
        cyc(3);
        chk("silent", 0, ev_n);
        cfg(1'b1, 16'h0000);
        chk("active", 1'b0, act);
        $display("test wakeup done");
        cv[6] = $urandom_range(1023, 0) - 511;
        foreach (cv[i]) begin
            cal_i = cv[i][10:0];
            cal_wr_i = 1'b1;
            cyc(1);
            cal_wr_i = 1'b0;
            cyc(1);
            chk("cal", clamp(cv[i]), cal_o);
        end
        $display("test calibration done");
        // Second reset from the external input, oscillator already running
        por = 1'b0;
        ext = 1'b1;
        rstn_i = 1'b0;
        cyc(2);
        rstn_i = 1'b1;
        cyc(3);
        chk("info", 18'h20000, info);
        $display("test reset cause done");
        // One added tick wraps a step early, one dropped tick a step late
        cal_run(11'sd1, 127, 8'h04);
        cal_run(-11'sd1, 128, 8'h05);
        $display("test smooth calibration done");
        conclude();
    end
endmodule
